// ---- core/fpu_exc_map.svh ----
`ifndef FPU_EXC_MAP_SVH
`define FPU_EXC_MAP_SVH

// Register word indices; byte address is four times the index
`define WIX_CTRL   6'h00
`define WIX_STATUS 6'h01
`define WIX_CLEAR  6'h02
`define WIX_ENABLE 6'h03
`define WIX_TAG    6'h04
`define WIX_SIP    6'h05
`define WIX_SCS    6'h06

// Control register fields, writable bits and reset value
`define CTRL_RC_LSB 8
`define CTRL_PC_LSB 12
`define CTRL_WMASK  32'h0000_331F
`define CTRL_RESET  32'h0000_301F

// Event bit positions in status, clear and enable
`define EV_INV 0
`define EV_DEN 1
`define EV_OVF 2
`define EV_UNF 3
`define EV_PRE 4
`define EV_STO 5
`define EV_W   6

// Two-bit tag codes
`define TAG_VALID 2'h0
`define TAG_ZERO  2'h1
`define TAG_SPEC  2'h2
`define TAG_EMPTY 2'h3

// Rounding and precision codes
`define RC_DOWN 2'h1
`define RC_UP   2'h2
`define RC_CHOP 2'h3
`define PC_EXT  2'h3

// Extended format exponents
`define EXP_MAX 15'h7FFF
`define EXP_BIG 15'h7FFE

`endif

// ---- core/fpu_exc_pkg.sv ----
package fpu_exc_pkg;
	typedef enum logic [2:0] {
		arith_instr, compare_instr, store_integer_instr,
		store_bcd_pop_instr, transcend_instr, extract_exponent_instr
	} op_kind_t;
	typedef enum logic [2:0] {
		cls_zero, cls_normal, cls_denorm, cls_inf,
		quiet_nan, signaling_nan, cls_unsup
	} cls_t;
	typedef enum logic [1:0] {st_idle, st_eval, st_scan, st_pub} state_t;
endpackage : fpu_exc_pkg

// ---- core/fpu_ram_if.sv ----
`timescale 1ns/1ps
interface fpu_ram_if #(parameter int IDXW = 3);
	logic            we;
	logic [IDXW-1:0] waddr;
	logic [79:0]     wdata;
	logic [IDXW-1:0] raddr;
	logic [79:0]     rdata;
	modport ram  (input we, waddr, wdata, raddr, output rdata);
	modport user (output we, waddr, wdata, raddr, input rdata);
endinterface : fpu_ram_if

// ---- core/fpu_data_ram.sv ----
`timescale 1ns/1ps
module fpu_data_ram #(
	parameter int DEPTH = 8
) (
	input  wire logic ref_clk_i,
	fpu_ram_if.ram    bus
);
	logic [79:0] mem [DEPTH];

	// Depth must be a power of two to match the index width
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
		$error("fpu_data_ram: DEPTH must be a power of two");
	end

	// Write port and registered read port
	always_ff @(posedge ref_clk_i) begin
		if (bus.we) begin
			mem[bus.waddr] <= bus.wdata;
		end
		bus.rdata <= mem[bus.raddr];
	end
endmodule : fpu_data_ram

// ---- core/fpu_tag_exc.sv ----
`timescale 1ns/1ps
`include "fpu_exc_map.svh"
// Operation
// - Loaded tags 00, 01, 10 just mark the register non-empty.
// - Loaded tag 11 marks the register empty.
// - Operand class comes from register contents, never the loaded tag.
// - Store rescans every non-empty register and recomputes its tag.
// - Unsupported encodings, pseudo-zero and unnormal, get the special tag.
// - Signaling and quiet NaN are told apart; produced NaNs are quiet.
// - Signaling NaN raises invalid; quiet NaN only for compare and stores.
// - Pseudo and unnormal operands raise invalid and are never produced.
// - Masked denormal operand asks for automatic normalization.
// - Transcendental and extract instructions also raise denormal.
// - Masked overflow rounding toward zero gives largest finite value.
// - Unmasked overflow also sets the precision flag.
// - Unmasked overflow to stack rounds by precision field or opcode.
// - Masked underflow only when tiny and inexact after denormalizing.
// - Unmasked underflow to stack adjusts exponent, then rounds.
// - Denormal keeps one fixed priority whether masked or not.
// - Saved instruction pointer addresses the first prefix byte.
module fpu_tag_exc import fpu_exc_pkg::*; #(
	parameter int REGS = 8
) (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [31:0]         wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	output logic                     irq_o,
	input  wire logic                reg_wr_i,
	input  wire logic [$clog2(REGS)-1:0] reg_wr_idx_i,
	input  wire logic [79:0]         reg_wr_data_i,
	input  wire logic                op_valid_i,
	input  wire op_kind_t            op_kind_i,
	input  wire logic [$clog2(REGS)-1:0] op_idx_i,
	input  wire logic                res_sign_i,
	input  wire logic                res_ovf_i,
	input  wire logic                res_tiny_i,
	input  wire logic                res_lossy_i,
	input  wire logic                dest_stack_i,
	input  wire logic                pc_applies_i,
	input  wire logic                opc_prec_vld_i,
	input  wire logic [1:0]          opc_prec_i,
	input  wire logic [31:0]         opcode_ip_i,
	input  wire logic [3:0]          prefix_len_i,
	input  wire logic [15:0]         code_seg_i,
	input  wire logic                env_load_i,
	input  wire logic [2*REGS-1:0]   env_tag_i,
	input  wire logic                env_store_i,
	output logic                     busy_o,
	output logic [2*REGS-1:0]        tag_word_o,
	output logic                     store_done_o,
	output logic                     op_done_o,
	output logic                     fault_o,
	output logic [2:0]               exc_code_o,
	output logic [4:0]               exc_flags_o,
	output logic                     res_force_o,
	output logic [79:0]              res_value_o,
	output logic                     normalize_o,
	output logic                     exp_adjust_o,
	output logic [1:0]               round_prec_o
);
	localparam int IDXW = $clog2(REGS);

	// Tag word must fit one bus word
	if (REGS < 2 || REGS > 16 || (REGS & (REGS - 1)) != 0) begin : g_bad
		$error("fpu_tag_exc: REGS must be a power of two, 2 to 16");
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// Class of an extended value from its bits alone
	function automatic cls_t classify(input logic [79:0] x);
		logic fz;
		fz = (x[62:0] == 63'h0);
		if (x[78:64] == 15'h0000)
			classify = (!x[63] && fz) ? cls_zero : cls_denorm;
		else if (x[78:64] == `EXP_MAX) begin
			if (!x[63])
				classify = cls_unsup;
			else if (fz)
				classify = cls_inf;
			else
				classify = x[62] ? quiet_nan : signaling_nan;
		end else
			classify = x[63] ? cls_normal : cls_unsup;
	endfunction : classify

	// Tag code for a class; all unsupported forms are special
	function automatic logic [1:0] tag_of(input cls_t c);
		if (c == cls_zero)
			tag_of = `TAG_ZERO;
		else if (c == cls_normal)
			tag_of = `TAG_VALID;
		else
			tag_of = `TAG_SPEC;
	endfunction : tag_of

	state_t            state_ff, nxt_state;
	logic [IDXW:0]     cnt_ff, nxt_cnt;
	logic [REGS-1:0]   nonempty_ff;
	logic [1:0]        cls_tag_ff [REGS];
	logic [2*REGS-1:0] tag_live;
	logic [31:0]       ctrl_ff, sip_ff;
	logic [15:0]       scs_ff;
	logic [`EV_W-1:0]  status_ff, en_ff, nxt_status;
	logic              ack_ff;
	logic [31:0]       rd_ff;

	// Data register file
	fpu_ram_if #(.IDXW(IDXW)) ram_bus ();
	fpu_data_ram #(.DEPTH(REGS)) u_ram (
		.ref_clk_i (ref_clk_i),
		.bus       (ram_bus)
	);

	// Request acceptance: load over store over operation
	wire idle      = (state_ff == st_idle);
	wire load_acc  = idle & env_load_i;
	wire store_acc = idle & env_store_i & ~env_load_i;
	wire op_acc    = idle & op_valid_i & ~env_load_i & ~env_store_i;
	wire scan_hit  = (state_ff == st_scan) && (cnt_ff != '0);
	wire [IDXW-1:0] scan_idx = IDXW'(cnt_ff - 1'b1);
	assign busy_o = ~idle;

	// Memory ports
	assign ram_bus.we    = reg_wr_i;
	assign ram_bus.waddr = reg_wr_idx_i;
	assign ram_bus.wdata = reg_wr_data_i;
	assign ram_bus.raddr = (state_ff == st_scan) ? cnt_ff[IDXW-1:0]
	                                            : op_idx_i;

	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		unique case (state_ff)
			st_idle: begin
				nxt_cnt = '0;
				if (store_acc)
					nxt_state = st_scan;
				else if (op_acc)
					nxt_state = st_eval;
			end
			st_eval: nxt_state = st_idle;
			st_scan: begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == (IDXW+1)'(REGS))
					nxt_state = st_pub;
			end
			st_pub: nxt_state = st_idle;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff <= st_idle;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	// Per-register emptiness and tag class
	wire cls_t scan_cls = classify(ram_bus.rdata);
	for (genvar i = 0; i < REGS; i++) begin : g_tag
		wire [1:0] in_tag = env_tag_i[2*i +: 2];
		always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				nonempty_ff[i] <= 1'b0;
				cls_tag_ff[i]  <= `TAG_VALID;
			end else if (load_acc) begin
				nonempty_ff[i] <= (in_tag != `TAG_EMPTY);
				cls_tag_ff[i]  <= `TAG_VALID;
			end else if (reg_wr_i && reg_wr_idx_i == IDXW'(i)) begin
				nonempty_ff[i] <= 1'b1;
				cls_tag_ff[i]  <= tag_of(classify(reg_wr_data_i));
			end else if (scan_hit && scan_idx == IDXW'(i)
			             && nonempty_ff[i]) begin
				cls_tag_ff[i] <= tag_of(scan_cls);
			end
		end
		assign tag_live[2*i +: 2] = nonempty_ff[i] ? cls_tag_ff[i]
		                                           : `TAG_EMPTY;
	end

	// Control fields
	wire [4:0] mask  = ctrl_ff[4:0];
	wire [1:0] rc    = ctrl_ff[`CTRL_RC_LSB +: 2];
	wire [1:0] pc    = ctrl_ff[`CTRL_PC_LSB +: 2];
	wire m_inv = mask[`EV_INV];
	wire m_den = mask[`EV_DEN];
	wire m_ovf = mask[`EV_OVF];
	wire m_unf = mask[`EV_UNF];

	// Operand checks from register contents
	wire cls_t op_cls = classify(ram_bus.rdata);
	wire empty  = ~nonempty_ff[op_idx_i];
	wire strict = (op_kind_i == compare_instr)
	            | (op_kind_i == store_integer_instr)
	            | (op_kind_i == store_bcd_pop_instr);
	wire is_nan = ~empty & ((op_cls == quiet_nan)
	            | (op_cls == signaling_nan));
	wire ev_inv = empty | (op_cls == signaling_nan)
	            | (op_cls == cls_unsup)
	            | ((op_cls == quiet_nan) & strict);
	wire ev_den = ~ev_inv & (op_cls == cls_denorm);
	wire ev_ovf = ~ev_inv & res_ovf_i;
	wire ev_unf = ~ev_inv & res_tiny_i & (~m_unf | res_lossy_i);
	wire ev_pre = ~ev_inv & (res_lossy_i | (res_ovf_i & ~m_ovf));
	wire [4:0] evt = {ev_pre, ev_unf, ev_ovf, ev_den, ev_inv};
	wire [4:0] um  = evt & ~mask;

	// Fixed priority, independent of masking
	wire [2:0] code = um[0] ? 3'h0 : um[1] ? 3'h1 : um[2] ? 3'h2
	                : um[3] ? 3'h3 : 3'h4;

	// Masked responses; no pseudo form is ever built
	wire maxfin = (rc == `RC_CHOP) | ((rc == `RC_DOWN) & ~res_sign_i)
	            | ((rc == `RC_UP) & res_sign_i);
	wire [79:0] v_quiet_nan = {ram_bus.rdata[79:63], 1'b1,
	                      ram_bus.rdata[61:0]};
	wire [79:0] v_ind  = {1'b1, `EXP_MAX, 2'h3, 62'h0};
	wire [79:0] v_big  = {res_sign_i, `EXP_BIG, 64'hFFFF_FFFF_FFFF_FFFF};
	wire [79:0] v_inf  = {res_sign_i, `EXP_MAX, 1'b1, 63'h0};
	wire force_r = (ev_inv & m_inv) | (ev_ovf & m_ovf);
	wire [79:0] value = ev_inv ? (is_nan ? v_quiet_nan : v_ind)
	                  : (maxfin ? v_big : v_inf);

	// Unmasked overflow or underflow to the stack
	wire ovf_u  = ev_ovf & ~m_ovf;
	wire unf_u  = ev_unf & ~m_unf;
	wire adjust = dest_stack_i & (ovf_u | unf_u);
	wire [1:0] prec = ovf_u ? (opc_prec_vld_i ? opc_prec_i : pc)
	                : (pc_applies_i ? pc : `PC_EXT);

	// Operation results, held until the next operation
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			exc_flags_o  <= '0;
			exc_code_o   <= '0;
			fault_o      <= 1'b0;
			res_force_o  <= 1'b0;
			res_value_o  <= '0;
			normalize_o  <= 1'b0;
			exp_adjust_o <= 1'b0;
			round_prec_o <= `PC_EXT;
		end else if (state_ff == st_eval) begin
			exc_flags_o  <= evt;
			exc_code_o   <= code;
			fault_o      <= |um;
			res_force_o  <= force_r;
			res_value_o  <= value;
			normalize_o  <= ev_den & m_den;
			exp_adjust_o <= adjust;
			round_prec_o <= prec;
		end
	end

	// Completion pulses and stored tag word
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			op_done_o    <= 1'b0;
			store_done_o <= 1'b0;
			tag_word_o   <= {REGS{`TAG_EMPTY}};
		end else begin
			op_done_o    <= (state_ff == st_eval);
			store_done_o <= (state_ff == st_pub);
			if (state_ff == st_pub)
				tag_word_o <= tag_live;
		end
	end

	// Saved location of the faulting instruction
	wire [31:0] first_byte = opcode_ip_i - {28'h0, prefix_len_i};
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sip_ff <= '0;
			scs_ff <= '0;
		end else if (state_ff == st_eval && |um) begin
			sip_ff <= first_byte;
			scs_ff <= code_seg_i;
		end
	end

	// Bus decode, written at the edge where ack is seen
	wire        wb_req = wb_cyc_i & wb_stb_i;
	wire [5:0]  wix    = wb_adr_i[7:2];
	wire        wb_wr  = wb_req & wb_we_i & ack_ff;
	wire [31:0] bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
	                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] cmask  = bmask & `CTRL_WMASK;
	wire wr_ctrl = wb_wr & (wix == `WIX_CTRL);
	wire wr_clr  = wb_wr & (wix == `WIX_CLEAR);
	wire wr_en   = wb_wr & (wix == `WIX_ENABLE);
	wire [`EV_W-1:0] clr = wr_clr ? (wb_dat_i[`EV_W-1:0]
	                     & bmask[`EV_W-1:0]) : '0;
	wire [`EV_W-1:0] set = {(state_ff == st_pub),
	                        (state_ff == st_eval) ? evt : 5'h00};
	assign nxt_status = (status_ff & ~clr) | set;

	// Read selection; unmapped words read zero
	wire [31:0] rd_word =
		(wix == `WIX_CTRL)   ? ctrl_ff :
		(wix == `WIX_STATUS) ? 32'(status_ff) :
		(wix == `WIX_ENABLE) ? 32'(en_ff) :
		(wix == `WIX_TAG)    ? 32'(tag_live) :
		(wix == `WIX_SIP)    ? sip_ff :
		(wix == `WIX_SCS)    ? 32'(scs_ff) : 32'h0000_0000;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_ff <= 1'b0;
			rd_ff  <= '0;
		end else begin
			ack_ff <= wb_req & ~ack_ff;
			rd_ff  <= rd_word;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rd_ff;

	// Software registers and sticky status
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_ff   <= `CTRL_RESET;
			en_ff     <= '0;
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
			if (wr_ctrl)
				ctrl_ff <= (ctrl_ff & ~cmask) | (wb_dat_i & cmask);
			if (wr_en)
				en_ff <= (en_ff & ~bmask[`EV_W-1:0])
				       | (wb_dat_i[`EV_W-1:0] & bmask[`EV_W-1:0]);
		end
	end
	assign irq_o = |(status_ff & en_ff);

	// Load of the tag word
	logic [REGS-1:0] load_ne;
	for (genvar k = 0; k < REGS; k++) begin : g_ne
		assign load_ne[k] = (env_tag_i[2*k +: 2] != `TAG_EMPTY);
	end
	a_load_nonempty: assert property (
		load_acc |=> (nonempty_ff & $past(load_ne)) == $past(load_ne))
		else $error("loaded non-empty tag left register empty");
	a_load_empty: assert property (
		load_acc ##1 !reg_wr_i |-> (nonempty_ff & ~$past(load_ne)) == '0)
		else $error("loaded empty tag left register non-empty");

	// Store sequence
	sequence s_store_go;
		store_acc;
	endsequence
	sequence s_store_end;
		store_done_o && !busy_o ##1 !store_done_o;
	endsequence
	a_store_scan: assert property (
		s_store_go |=> busy_o [*8] ##2 busy_o ##1 s_store_end)
		else $error("tag store did not finish in eleven cycles");

	// Operation outcomes
	a_nan_quiet: assert property (
		res_force_o && res_value_o[78:64] == `EXP_MAX
		&& res_value_o[62:0] != 63'h0
		|-> res_value_o[63:62] == 2'h3)
		else $error("produced NaN is not quiet");
	a_signaling_nan_invalid: assert property (
		state_ff == st_eval && !empty && op_cls == signaling_nan
		|=> op_done_o && exc_flags_o[`EV_INV])
		else $error("signaling NaN did not raise invalid");
	a_no_pseudo: assert property (
		res_force_o |-> classify(res_value_o) != cls_unsup)
		else $error("unsupported encoding produced");
	a_ovf_chop: assert property (
		state_ff == st_eval && ev_ovf && m_ovf && rc == `RC_CHOP
		|=> res_force_o && res_value_o[78:64] == `EXP_BIG)
		else $error("masked chop overflow not largest finite");
	a_ovf_prec: assert property (
		op_done_o && exc_flags_o[`EV_OVF] && !ctrl_ff[`EV_OVF]
		|-> exc_flags_o[`EV_PRE])
		else $error("unmasked overflow without precision flag");
	a_fault_ip: assert property (
		state_ff == st_eval && |um
		|=> fault_o && sip_ff == $past(first_byte))
		else $error("saved pointer is not the first prefix byte");
endmodule : fpu_tag_exc

// ---- tb/core_model.sv ----
`timescale 1ns/1ps
// Integer core side: issues operations, data writes and tag traffic
module core_model import fpu_exc_pkg::*; (
	input  wire logic   clk_i,
	input  wire logic   busy_i,
	output logic        opv_o,
	output op_kind_t    kind_o,
	output logic [2:0]  idx_o,
	output logic [8:0]  ctl_o,
	output logic [51:0] at_o,
	output logic        rwr_o,
	output logic [79:0] rdat_o,
	output logic        ld_o,
	output logic [15:0] tag_o,
	output logic        st_o
);
	// Quiet outputs at time zero
	initial begin
		{opv_o, rwr_o, ld_o, st_o, idx_o, ctl_o, at_o, rdat_o, tag_o} = '0;
		kind_o = arith_instr;
	end

	// A request stays up until an edge finds the unit idle
	task automatic take();
		do @(posedge clk_i); while (busy_i !== 1'b0);
	endtask : take

	// Operands and result hints hold until the next request
	task automatic op(op_kind_t k, logic [2:0] i, logic [8:0] c,
		logic [51:0] a);
		@(posedge clk_i);
		kind_o <= k;
		idx_o  <= i;
		ctl_o  <= c;
		at_o   <= a;
		opv_o  <= 1'b1;
		take();
		opv_o  <= 1'b0;
	endtask : op

	// Data writes land at once and repeat until an edge finds the unit idle
	task automatic wreg(logic [2:0] i, logic [79:0] d);
		@(posedge clk_i);
		idx_o  <= i;
		rdat_o <= d;
		rwr_o  <= 1'b1;
		take();
		rwr_o  <= 1'b0;
	endtask : wreg

	task automatic load(logic [15:0] t);
		@(posedge clk_i);
		tag_o <= t;
		ld_o  <= 1'b1;
		take();
		ld_o  <= 1'b0;
	endtask : load

	task automatic store();
		@(posedge clk_i);
		st_o <= 1'b1;
		take();
		st_o <= 1'b0;
	endtask : store
endmodule : core_model

// ---- tb/fpu_tag_exc_tb.sv ----
`timescale 1ns/1ps
`include "fpu_exc_map.svh"
module fpu_tag_exc_tb import fpu_exc_pkg::*;;
	typedef struct {
		logic [13:0] s;
		logic [13:0] m;
		logic [79:0] r;
	} note_t;
	logic        clk, rst_b, cyc, ack, we, irq, busy, sdn, odn, flt;
	logic        frc, nrm, adj, opv, rwr, ld, st;
	logic [31:0] adr, wd, rd, ctrl;
	logic [79:0] rv, rdat;
	logic [15:0] tw, ltag;
	logic [51:0] at;
	logic [47:0] sv;
	logic [8:0]  ctl;
	logic [7:0]  emp;
	logic [5:0]  sts;
	logic [4:0]  flg;
	logic [3:0]  sel;
	logic [2:0]  code, idx;
	logic [1:0]  rp;
	op_kind_t    kind;
	cls_t        cl [8];
	logic [79:0] vl [8];
	note_t       qo [$];
	logic [32:0] qr [$];
	logic [15:0] qt [$];
	note_t       nt;
	logic [32:0] nr;
	int          err_total, cmp_count, cyc_n;

	fpu_tag_exc #(.REGS(8)) DUT (
		.ref_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
		.wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq), .reg_wr_i(rwr),
		.reg_wr_idx_i(idx), .reg_wr_data_i(rdat), .op_valid_i(opv),
		.op_kind_i(kind), .op_idx_i(idx), .res_sign_i(ctl[8]),
		.res_ovf_i(ctl[7]), .res_tiny_i(ctl[6]), .res_lossy_i(ctl[5]),
		.dest_stack_i(ctl[4]), .pc_applies_i(ctl[3]),
		.opc_prec_vld_i(ctl[2]), .opc_prec_i(ctl[1:0]),
		.opcode_ip_i(at[51:20]), .prefix_len_i(at[19:16]),
		.code_seg_i(at[15:0]), .env_load_i(ld), .env_tag_i(ltag),
		.env_store_i(st), .busy_o(busy), .tag_word_o(tw),
		.store_done_o(sdn), .op_done_o(odn), .fault_o(flt),
		.exc_code_o(code), .exc_flags_o(flg), .res_force_o(frc),
		.res_value_o(rv), .normalize_o(nrm), .exp_adjust_o(adj),
		.round_prec_o(rp)
	);
	core_model core (
		.clk_i(clk), .busy_i(busy), .opv_o(opv), .kind_o(kind),
		.idx_o(idx), .ctl_o(ctl), .at_o(at), .rwr_o(rwr), .rdat_o(rdat),
		.ld_o(ld), .tag_o(ltag), .st_o(st)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(string w, logic [79:0] s, logic [79:0] e);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", w, e, s);
		end
	endtask : chk

	task automatic wrap_up();
		$display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	// Single classic cycle; the answer is judged by the monitor
	task automatic wb(logic w, logic [5:0] x, logic [31:0] d, logic c,
		logic [31:0] e);
		int n;
		qr.push_back({c, e});
		@(posedge clk);
		cyc <= 1'b1;
		we  <= w;
		adr <= {24'h0, x, 2'h0};
		wd  <= d;
		sel <= 4'hF;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		cyc <= 1'b0;
		if (ack !== 1'b1)
			err_total++;
	endtask : wb

	task automatic wr(logic [5:0] x, logic [31:0] d);
		wb(1'b1, x, d, 1'b0, 32'h0);
	endtask : wr

	task automatic rdc(logic [5:0] x, logic [31:0] e);
		wb(1'b0, x, 32'h0, 1'b1, e);
	endtask : rdc

	task automatic irqchk(logic e);
		repeat (2) @(posedge clk);
		#1;
		chk("irq", irq, e);
	endtask : irqchk

	// Register image of each class, fraction random
	function automatic logic [79:0] mkval(cls_t c);
		logic [63:0] f;
		logic [14:0] e;
		f = {$urandom, $urandom};
		e = 15'($urandom_range(32766, 1));
		case (c)
			cls_zero: return {f[63], 15'h0, 64'h0};
			cls_normal: return {f[63], e, 1'b1, f[62:0]};
			cls_denorm: return {f[63], 15'h0, 1'b0, f[62:1], 1'b1};
			cls_inf: return {f[63], `EXP_MAX, 1'b1, 63'h0};
			quiet_nan: return {f[63], `EXP_MAX, 2'h3, f[61:0]};
			signaling_nan: return {f[63], `EXP_MAX, 2'h2, f[61:1], 1'b1};
			default: return {f[63], f[0] ? `EXP_MAX : e, 1'b0,
				f[1] ? f[62:0] : 63'h0};
		endcase
	endfunction : mkval

	function automatic logic [15:0] tword(logic lv);
		logic [15:0] t;
		for (int i = 0; i < 8; i++)
			t[2*i +: 2] = emp[i] ? `TAG_EMPTY : lv ? `TAG_VALID :
				cl[i] == cls_zero ? `TAG_ZERO :
				cl[i] == cls_normal ? `TAG_VALID : `TAG_SPEC;
		return t;
	endfunction : tword

	// Expected outputs of one operation from class, masks and hints
	function automatic note_t exp_op(op_kind_t k, logic [2:0] i,
		logic [8:0] c);
		note_t n;
		logic [4:0] m, f, u;
		logic inv, nan;
		m = ctrl[4:0];
		nan = !emp[i] && cl[i] inside {quiet_nan, signaling_nan};
		inv = emp[i] || cl[i] inside {signaling_nan, cls_unsup} ||
			(nan && k inside {compare_instr, store_integer_instr,
			store_bcd_pop_instr});
		f = {!inv && (c[5] || c[7] && !m[2]),
			!inv && c[6] && (c[5] || !m[3]), !inv && c[7],
			!inv && cl[i] == cls_denorm, inv};
		u = f & ~m;
		n.s = {(inv & m[0]) | (f[2] & m[2]),
			c[3] ? ctrl[13:12] : c[2] ? c[1:0] : 2'h3,
			c[4] & (u[2] | u[3]), f[1] & m[1], |u,
			u[0] ? 3'h0 : u[1] ? 3'h1 : u[2] ? 3'h2 : u[3] ? 3'h3 : 3'h4, f};
		n.m = {!(c[6] && !inv),
			{2{n.s[10] && (c[3] || (u[2] ? c[2] : !c[2]))}}, 11'h7FF};
		n.r = inv ? (nan ? vl[i] | 80'h4000_0000_0000_0000 :
			80'hFFFF_C000_0000_0000_0000) :
			(ctrl[9:8] == `RC_CHOP || ctrl[9:8] == (c[8] ? `RC_UP : `RC_DOWN))
			? {c[8], `EXP_BIG, 64'hFFFF_FFFF_FFFF_FFFF} :
			{c[8], `EXP_MAX, 1'b1, 63'h0};
		return n;
	endfunction : exp_op

	task automatic fill(logic rnd);
		for (int i = 0; i < 8; i++) begin
			cl[i] = cls_t'(rnd ? $urandom_range(6, 0) : (i > 6 ? 6 : i));
			vl[i] = mkval(cl[i]);
			emp[i] = 1'b0;
			core.wreg(3'(i), vl[i]);
		end
		qt.push_back(tword(1'b0));
		core.store();
		sts[`EV_STO] = 1'b1;
	endtask : fill

	// Compares each result the unit shows with the oldest note
	always @(posedge clk) begin
		#1;
		if (ack === 1'b1 && qr.size() > 0) begin
			nr = qr.pop_front();
			if (nr[32])
				chk("read data", rd, nr[31:0]);
		end
		if (odn === 1'b1 && qo.size() > 0) begin
			nt = qo.pop_front();
			chk("op outputs", {frc, rp, adj, nrm, flt, code, flg} & nt.m,
				nt.s & nt.m);
			if (nt.m[13] && nt.s[13])
				chk("result", rv, nt.r);
		end
		if (sdn === 1'b1 && qt.size() > 0)
			chk("tag word", tw, qt.pop_front());
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 10000) begin
			err_total++;
			wrap_up();
		end
	end

	initial begin
		note_t e;
		logic [8:0] c;
		logic [51:0] a;
		logic [15:0] t;
		op_kind_t    k;
		{rst_b, cyc, we, adr, wd, ctrl, sts, sv, sel} = '0;
		emp = 8'hFF;
		void'($urandom(38136));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		ctrl = `CTRL_RESET;
		rdc(`WIX_CTRL, `CTRL_RESET);
		rdc(`WIX_TAG, 32'h0000_FFFF);
		rdc(6'h3F, 32'h0);
		chk("tag word", tw, 16'hFFFF);
		$display("reset test done");
		fill(1'b0);
		rdc(`WIX_TAG, {16'h0, tword(1'b0)});
		$display("tag test done");
		// Loaded tags keep only empty or non-empty
		for (int j = 0; j < 8; j++)
			t[2*j +: 2] = j == 0 ? 2'h3 : 2'($urandom_range(2, 0));
		emp = 8'h01;
		core.load(t);
		rdc(`WIX_TAG, {16'h0, tword(1'b1)});
		qt.push_back(tword(1'b0));
		core.store();
		$display("load test done");
		// Random operations over kinds, classes, masks and rounding
		for (int n = 0; n < 300; n++) begin
			if (n % 50 == 0) begin
				ctrl = $urandom & `CTRL_WMASK;
				wr(`WIX_CTRL, ctrl);
				rdc(`WIX_CTRL, ctrl);
			end
			if (n == 150)
				fill(1'b1);
			c = 9'($urandom);
			t = 16'($urandom_range(2, 0));
			c[7] = t == 16'h1;
			c[6] = t == 16'h2;
			c[2] = c[2] & !c[3];
			a = {$urandom, 20'($urandom)};
			k = op_kind_t'($urandom_range(5, 0));
			e = exp_op(k, 3'(n), c);
			qo.push_back(e);
			sts[4:0] |= e.s[4:0];
			if (e.s[8])
				sv = {a[51:20] - 32'(a[19:16]), a[15:0]};
			core.op(k, 3'(n), c, a);
		end
		$display("operation test done");
		repeat (20) @(posedge clk);
		rdc(`WIX_STATUS, {26'h0, sts});
		wr(`WIX_STATUS, 32'h3F);
		rdc(`WIX_STATUS, {26'h0, sts});
		wr(`WIX_ENABLE, 32'h20);
		irqchk(1'b1);
		wr(`WIX_CLEAR, 32'h20);
		sts[`EV_STO] = 1'b0;
		irqchk(1'b0);
		wr(`WIX_ENABLE, 32'h1F);
		rdc(`WIX_ENABLE, 32'h1F);
		irqchk(|sts[4:0]);
		wr(`WIX_CLEAR, 32'h3F);
		irqchk(1'b0);
		rdc(`WIX_STATUS, 32'h0);
		rdc(`WIX_SIP, sv[47:16]);
		rdc(`WIX_SCS, {16'h0, sv[15:0]});
		$display("interrupt test done");
		repeat (4) @(posedge clk);
		chk("pending", qo.size() + qt.size() + qr.size(), 0);
		wrap_up();
	end
endmodule : fpu_tag_exc_tb
